/* hdl/baud_pkg.sv */
// Package: register map, field layout and timing counts of the baud rate generator
package baud_pkg;

    // ***********************************
    // Register offsets (byte addresses)
    // ***********************************
    localparam int          ADDR_W         = 8;
    localparam logic [7:0]  OFF_WIDE_CTRL  = 8'h00;
    localparam logic [7:0]  OFF_POWER      = 8'h04;
    localparam logic [7:0]  OFF_WIDE_COUNT = 8'h08;
    localparam logic [7:0]  OFF_RELOAD     = 8'h0C;
    localparam logic [7:0]  OFF_STATUS     = 8'h10;
    localparam logic [7:0]  OFF_MASK       = 8'h14;

    // ***********************************
    // Field positions
    // ***********************************
    localparam int          POWER_DBL      = 0;
    localparam int          STAT_OVF       = 0;
    localparam int          STAT_EXT       = 1;
    localparam int          CTRL_W         = 5;
    localparam int          STAT_W         = 2;

    // ***********************************
    // Reset values
    // ***********************************
    localparam logic [15:0] COUNT_RST      = 16'h0000;
    localparam logic [15:0] RELOAD_RST     = 16'h0000;
    localparam logic [15:0] COUNT_TOP      = 16'hFFFF;

    // ***********************************
    // Timing counts: STATE_DIV and MACHINE_DIV in oscillator clocks, divider counts in overflow pulses
    // ***********************************
    localparam int          STATE_DIV      = 2;
    localparam int          MACHINE_DIV    = 12;
    localparam int          NARROW_DIV     = 32;
    localparam int          NARROW_DIV_DBL = 16;
    localparam int          WIDE_DIV       = 16;
    localparam int          WIDE_SPAN      = 65536;

    // Bit order matches the control register, bit 4 first
    typedef struct packed {
        logic src_sel;
        logic ext_en;
        logic run;
        logic rx_sel;
        logic tx_sel;
    } ctrl_t;

    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic              pwrite;
        logic [31:0]       pwdata;
        logic              psel;
        logic              penable;
    } apb_req_t;

    typedef struct packed {
        logic rx;
        logic tx;
    } baud_ticks_t;

endpackage

/* hdl/tick_divider.sv */
// Module: free-running step divider emitting one-cycle ticks
module tick_divider
    import baud_pkg::*;
#(
    parameter int WIDTH = 5
) (
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic             step,
    input  wire logic [WIDTH-1:0] last,
    output wire logic             tick
);

    if (WIDTH < 1) begin : g_bad_width
        $error("tick_divider WIDTH must be at least 1");
    end

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic             tick;
    } div_t;

    div_t div_reg;
    div_t div_next;

    // ***********************************
    // Counter
    // ***********************************
    always_comb begin
        div_next      = div_reg;
        div_next.tick = 1'b0;
        if (step) begin
            if (div_reg.cnt >= last) begin
                div_next.cnt  = '0;
                div_next.tick = 1'b1;
            end else begin
                div_next.cnt = div_reg.cnt + WIDTH'(1);
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    assign tick = div_reg.tick;

    // ***********************************
    // Checks
    // ***********************************
    property p_tick_cause;
        @(posedge clock) disable iff (!rst_b)
        tick |-> $past(step) && ($past(div_reg.cnt) >= $past(last)) && div_reg.cnt == '0;
    endproperty
    a_tick_cause: assert property (p_tick_cause) else $error("tick without terminal count");

endmodule

/* hdl/baud_rate_generator.sv */
// Module: serial port baud rate generator with APB registers
module baud_rate_generator
    import baud_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire apb_req_t    apb,
    output wire logic [31:0] prdata,
    output wire logic        pready,
    output wire logic        pslverr,
    input  wire logic        timer8_overflow,
    input  wire logic        ext_trigger_pin,
    input  wire logic        wide_count_pin,
    output wire baud_ticks_t ticks,
    output wire logic        irq
);

    localparam logic [4:0] NARROW_LAST     = 5'(NARROW_DIV - 1);
    localparam logic [4:0] NARROW_LAST_DBL = 5'(NARROW_DIV_DBL - 1);
    localparam logic [4:0] WIDE_LAST       = 5'(WIDE_DIV - 1);
    localparam logic [3:0] MACHINE_LAST    = 4'(MACHINE_DIV - 1);

    typedef struct packed {
        logic [3:0]        mcnt;
        logic              phase;
        ctrl_t             ctrl;
        logic              rate_double_bit;
        logic [15:0]       count;
        logic [15:0]       reload;
        logic [STAT_W-1:0] status;
        logic [STAT_W-1:0] mask;
        logic [31:0]       rdata;
        logic              err;
        logic              ext_prev;
        logic              pin_prev;
        logic              wide_ovf;
    } gen_t;

    gen_t st_reg;
    gen_t st_next;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    // ***********************************
    // Bus decode
    // ***********************************
    logic setup;
    logic wr;
    logic mapped;
    logic baud_mode;
    logic state_tick;
    logic machine_tick;
    logic pin_fall;
    logic ext_fall;
    logic inc;
    logic ovf_now;
    logic narrow_tick;
    logic wide_tick;

    assign setup  = apb.psel && !apb.penable;
    assign wr     = apb.psel && apb.penable && apb.pwrite;
    assign mapped = hit(apb.paddr, OFF_WIDE_CTRL) || hit(apb.paddr, OFF_POWER)
                 || hit(apb.paddr, OFF_WIDE_COUNT) || hit(apb.paddr, OFF_RELOAD)
                 || hit(apb.paddr, OFF_STATUS) || hit(apb.paddr, OFF_MASK);

    // ***********************************
    // Wide timer stepping
    // ***********************************
    // select bits enter baud mode
    assign baud_mode    = st_reg.ctrl.tx_sel || st_reg.ctrl.rx_sel;
    assign state_tick   = st_reg.phase;
    assign machine_tick = (st_reg.mcnt == MACHINE_LAST);
    assign pin_fall     = st_reg.pin_prev && !wide_count_pin;
    assign ext_fall     = st_reg.ext_prev && !ext_trigger_pin;
    // state time steps in baud mode unless src_sel picks pin falls
    assign inc          = st_reg.ctrl.run
                       && (st_reg.ctrl.src_sel ? pin_fall : (baud_mode ? state_tick : machine_tick));
    assign ovf_now      = inc && (st_reg.count == COUNT_TOP);

    always_comb begin
        st_next          = st_reg;
        st_next.phase    = !st_reg.phase;
        st_next.mcnt     = machine_tick ? 4'h0 : st_reg.mcnt + 4'h1;
        st_next.ext_prev = ext_trigger_pin;
        st_next.pin_prev = wide_count_pin;
        st_next.wide_ovf = ovf_now && baud_mode;
        st_next.err      = 1'b0;

        if (inc) begin
            if (ovf_now) begin
                st_next.count = st_reg.reload;
            end else begin
                st_next.count = st_reg.count + 16'h0001;
            end
        end
        // Outside baud mode the trigger edge still reloads, as in auto-reload use
        if (ext_fall && st_reg.ctrl.ext_en && !baud_mode) begin
            st_next.count = st_reg.reload;
        end

        // Software writes; a count write racing a step wins, hence stop the timer first
        if (wr) begin
            if (hit(apb.paddr, OFF_WIDE_CTRL)) begin
                st_next.ctrl = ctrl_t'(apb.pwdata[CTRL_W-1:0]);
            end
            if (hit(apb.paddr, OFF_POWER)) begin
                st_next.rate_double_bit = apb.pwdata[POWER_DBL];
            end
            if (hit(apb.paddr, OFF_WIDE_COUNT)) begin
                st_next.count = apb.pwdata[15:0];
            end
            if (hit(apb.paddr, OFF_RELOAD)) begin
                st_next.reload = apb.pwdata[15:0];
            end
            if (hit(apb.paddr, OFF_STATUS)) begin
                st_next.status = st_reg.status & ~apb.pwdata[STAT_W-1:0];
            end
            if (hit(apb.paddr, OFF_MASK)) begin
                st_next.mask = apb.pwdata[STAT_W-1:0];
            end
        end

        // Hardware set wins over a clearing write in the same cycle
        // baud rollover leaves flag alone
        if (ovf_now && !baud_mode) begin
            st_next.status[STAT_OVF] = 1'b1;
        end
        if (ext_fall && st_reg.ctrl.ext_en) begin
            st_next.status[STAT_EXT] = 1'b1;
        end

        // Read data captured in setup, so access phase needs no wait
        if (setup) begin
            st_next.rdata = 32'h0000_0000;
            st_next.err   = !mapped;
            unique case (1'b1)
                hit(apb.paddr, OFF_WIDE_CTRL):  st_next.rdata[CTRL_W-1:0] = st_reg.ctrl;
                hit(apb.paddr, OFF_POWER):      st_next.rdata[POWER_DBL]  = st_reg.rate_double_bit;
                hit(apb.paddr, OFF_WIDE_COUNT): st_next.rdata[15:0]       = st_reg.count;
                hit(apb.paddr, OFF_RELOAD):     st_next.rdata[15:0]       = st_reg.reload;
                hit(apb.paddr, OFF_STATUS):     st_next.rdata[STAT_W-1:0] = st_reg.status;
                hit(apb.paddr, OFF_MASK):       st_next.rdata[STAT_W-1:0] = st_reg.mask;
                default:                        st_next.rdata             = 32'h0000_0000;
            endcase
        end else if (!apb.psel) begin
            st_next.err = 1'b0;
        end else begin
            st_next.err = st_reg.err;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_reg        <= '0;
            st_reg.count  <= COUNT_RST;
            st_reg.reload <= RELOAD_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata  = st_reg.rdata;
    assign pready  = apb.psel && apb.penable;
    assign pslverr = apb.psel && apb.penable && st_reg.err;
    assign irq     = |(st_reg.status & st_reg.mask);

    // ***********************************
    // Bit-rate dividers
    // ***********************************
    // narrow path by 32 or 16
    tick_divider #(
        .WIDTH (5)
    ) u_narrow_div (
        .clock (clock),
        .rst_b (rst_b),
        .step  (timer8_overflow),
        .last  (st_reg.rate_double_bit ? NARROW_LAST_DBL : NARROW_LAST),
        .tick  (narrow_tick)
    );

    tick_divider #(
        .WIDTH (5)
    ) u_wide_div (
        .clock (clock),
        .rst_b (rst_b),
        .step  (st_reg.wide_ovf),
        .last  (WIDE_LAST),
        .tick  (wide_tick)
    );

    logic [1:0] dir_sel;
    logic [1:0] dir_tick;
    assign dir_sel = {st_reg.ctrl.rx_sel, st_reg.ctrl.tx_sel};

    for (genvar i = 0; i < 2; i++) begin : g_dir
        assign dir_tick[i] = dir_sel[i] ? wide_tick : narrow_tick;
    end
    assign ticks = baud_ticks_t'(dir_tick);

    // ***********************************
    // Checks
    // ***********************************
    logic [17:0] gap;
    logic        clean;
    logic        base_steady;

    assign base_steady = baud_mode && st_reg.ctrl.run && !st_reg.ctrl.src_sel && !wr;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            gap   <= 18'h00000;
            clean <= 1'b0;
        end else if (st_reg.wide_ovf) begin
            gap   <= 18'h00000;
            clean <= base_steady;
        end else begin
            gap   <= gap + 18'h00001;
            clean <= clean && base_steady;
        end
    end

    sequence s_steady;
        base_steady;
    endsequence

    // Rollover inside the window is allowed, so short reloads are covered too
    property p_state_step;
        @(posedge clock) disable iff (!rst_b)
        s_steady [*3] |-> st_reg.count == (($past(st_reg.count, 2) == COUNT_TOP) ? st_reg.reload
                                                                                  : $past(st_reg.count, 2) + 16'h0001);
    endproperty
    a_state_step: assert property (p_state_step) else $error("baud timer not stepping every two clocks");

    property p_period;
        @(posedge clock) disable iff (!rst_b)
        (st_reg.wide_ovf && clean && base_steady)
            |-> 32'(gap) + 32'd1 == 32'(STATE_DIV) * (32'(WIDE_SPAN) - 32'(st_reg.reload));
    endproperty
    a_period: assert property (p_period) else $error("wide overflow period wrong");

    property p_reload;
        @(posedge clock) disable iff (!rst_b)
        (ovf_now && baud_mode && !wr) |=> st_reg.count == $past(st_reg.reload) && st_reg.wide_ovf;
    endproperty
    a_reload: assert property (p_reload) else $error("rollover did not reload");

    property p_no_flag;
        @(posedge clock) disable iff (!rst_b)
        $rose(st_reg.status[STAT_OVF]) |-> !$past(baud_mode) && $past(ovf_now);
    endproperty
    a_no_flag: assert property (p_no_flag) else $error("overflow flag set in baud mode");

    property p_mode_flag;
        @(posedge clock) disable iff (!rst_b)
        (ovf_now && !baud_mode) |=> st_reg.status[STAT_OVF] && !st_reg.wide_ovf;
    endproperty
    a_mode_flag: assert property (p_mode_flag) else $error("timer mode overflow lost");

    property p_ext;
        @(posedge clock) disable iff (!rst_b)
        (ext_fall && st_reg.ctrl.ext_en && baud_mode && !wr && !inc)
            |=> st_reg.status[STAT_EXT] && st_reg.count == $past(st_reg.count);
    endproperty
    a_ext: assert property (p_ext) else $error("trigger edge mishandled");

    property p_dbl_reset;
        @(posedge clock) disable iff (!rst_b)
        $rose(rst_b) |-> !st_reg.rate_double_bit;
    endproperty
    a_dbl_reset: assert property (p_dbl_reset) else $error("rate double not cleared by reset");

    property p_split;
        @(posedge clock) disable iff (!rst_b)
        (st_reg.ctrl.tx_sel && !st_reg.ctrl.rx_sel && wide_tick && !narrow_tick) |-> ticks.tx && !ticks.rx;
    endproperty
    a_split: assert property (p_split) else $error("directions not independent");

endmodule

/* bench/serial_shift_model.sv */
// Partner model: serial port tick period monitor and the 8-bit timer feeding it
module serial_shift_model
    import baud_pkg::*;
#(
    parameter int OVF_GAP = 4
) (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire baud_ticks_t ticks,
    output logic             timer8_overflow,
    output logic [15:0]      tx_period,
    output logic [15:0]      rx_period,
    output logic [15:0]      tx_n,
    output logic [15:0]      rx_n
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] ovf_cnt;
    logic [15:0] tx_gap;
    logic [15:0] rx_gap;

    // reload after every overflow
    // A fixed reload keeps the overflow pulse spacing exact
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ovf_cnt         <= 16'h0000;
            timer8_overflow <= 1'b0;
            tx_gap          <= 16'h0000;
            rx_gap          <= 16'h0000;
            tx_period       <= 16'h0000;
            rx_period       <= 16'h0000;
            tx_n            <= 16'h0000;
            rx_n            <= 16'h0000;
        end else begin
            ovf_cnt         <= (ovf_cnt == 16'(OVF_GAP - 1)) ? 16'h0000 : ovf_cnt + 16'h0001;
            timer8_overflow <= (ovf_cnt == 16'(OVF_GAP - 1));
            tx_gap          <= ticks.tx ? 16'h0001 : tx_gap + 16'h0001;
            rx_gap          <= ticks.rx ? 16'h0001 : rx_gap + 16'h0001;
            if (ticks.tx) begin
                tx_period <= tx_gap;
                tx_n      <= tx_n + 16'h0001;
            end
            if (ticks.rx) begin
                rx_period <= rx_gap;
                rx_n      <= rx_n + 16'h0001;
            end
        end
    end
endmodule

/* bench/serial_baud_rate_generator_test.sv */
// Testbench: register access, baud tick periods and trigger events
module serial_baud_rate_generator_test
    import baud_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock;
    logic        rst_b;
    apb_req_t    apb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        timer8_overflow;
    logic        ext_trigger_pin;
    logic        wide_count_pin;
    baud_ticks_t ticks;
    logic        irq;
    logic [15:0] tx_period;
    logic [15:0] rx_period;
    logic [15:0] tx_n;
    logic [15:0] rx_n;
    logic [31:0] q;
    logic        e;
    logic [15:0] tick_mark;
    int          miscompares;
    int          n_checks;

    baud_rate_generator i_dut (
        .clock           (clock),
        .rst_b           (rst_b),
        .apb             (apb),
        .prdata          (prdata),
        .pready          (pready),
        .pslverr         (pslverr),
        .timer8_overflow (timer8_overflow),
        .ext_trigger_pin (ext_trigger_pin),
        .wide_count_pin  (wide_count_pin),
        .ticks           (ticks),
        .irq             (irq)
    );

    serial_shift_model #(.OVF_GAP(4)) i_port (
        .clock           (clock),
        .rst_b           (rst_b),
        .ticks           (ticks),
        .timer8_overflow (timer8_overflow),
        .tx_period       (tx_period),
        .rx_period       (rx_period),
        .tx_n            (tx_n),
        .rx_n            (rx_n)
    );

    always #20 clock = ~clock;

    // ***********************************
    // Shared tasks
    // ***********************************
    task automatic complete_run();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Wait states are allowed by the bus, so the access phase is bounded, not fixed
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clock);
        apb <= '{paddr: a, pwrite: w, pwdata: d, psel: 1'b1, penable: 1'b0};
        @(posedge clock);
        apb.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        apb.psel    <= 1'b0;
        apb.penable <= 1'b0;
        if (pready !== 1'b1) begin
            miscompares++;
            complete_run();
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0000_0000);
        check(q, exp);
    endtask

    task automatic wait_ticks(input logic rx, input int k);
        int n;
        logic [15:0] c0;
        c0 = rx ? rx_n : tx_n;
        n = 0;
        while (((rx ? rx_n : tx_n) - c0) < 16'(k) && n < 5000) begin
            @(posedge clock);
            n++;
        end
        if (((rx ? rx_n : tx_n) - c0) < 16'(k)) begin
            miscompares++;
            complete_run();
        end
    endtask

    // ***********************************
    // Main sequence
    // ***********************************
    initial begin
        clock = 1'b0;
        rst_b = 1'b0;
        apb = '0;
        ext_trigger_pin = 1'b1;
        wide_count_pin = 1'b1;
        miscompares = 0;
        n_checks = 0;
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;

        for (int i = 0; i < 6; i++) begin
            rd_chk(8'(4 * i), 32'h0000_0000);
        end
        xfer(8'h18, 1'b0, 32'h0000_0000);
        check({31'h0, e}, 32'h0000_0001);
        check(q, 32'h0000_0000);
        check({31'h0, irq}, 32'h0000_0000);
        $display("test reset values done");

        // Reload written only while stopped
        xfer(OFF_RELOAD, 1'b1, 32'h0000_FFFF);
        xfer(OFF_WIDE_COUNT, 1'b1, 32'h0000_FFFF);
        xfer(OFF_WIDE_CTRL, 1'b1, 32'h0000_0005);
        wait_ticks(1'b0, 3);
        check({16'h0, tx_period}, 32'h0000_0020);
        xfer(OFF_WIDE_CTRL, 1'b1, 32'h0000_0001);
        xfer(OFF_RELOAD, 1'b1, 32'h0000_FFFE);
        rd_chk(OFF_RELOAD, 32'h0000_FFFE);
        xfer(OFF_WIDE_CTRL, 1'b1, 32'h0000_0005);
        wait_ticks(1'b0, 3);
        check({16'h0, tx_period}, 32'h0000_0040);
        rd_chk(OFF_STATUS, 32'h0000_0000);
        $display("test wide tx path done");

        // Receive alone selects baud mode; transmit falls back to the narrow path
        xfer(OFF_WIDE_CTRL, 1'b1, 32'h0000_0006);
        wait_ticks(1'b0, 3);
        wait_ticks(1'b1, 3);
        check({16'h0, rx_period}, 32'h0000_0040);
        check({16'h0, tx_period}, 32'h0000_0080);
        rd_chk(OFF_STATUS, 32'h0000_0000);
        xfer(OFF_POWER, 1'b1, 32'h0000_0001);
        rd_chk(OFF_POWER, 32'h0000_0001);
        wait_ticks(1'b0, 3);
        check({16'h0, tx_period}, 32'h0000_0040);
        check({16'h0, rx_period}, 32'h0000_0040);
        $display("test split directions done");

        // Trigger edge in baud mode, timer stopped so the count can be compared
        xfer(OFF_WIDE_CTRL, 1'b1, 32'h0000_000A);
        xfer(OFF_WIDE_COUNT, 1'b1, 32'h0000_1234);
        xfer(OFF_MASK, 1'b1, 32'h0000_0002);
        @(posedge clock);
        ext_trigger_pin <= 1'b0;
        rd_chk(OFF_STATUS, 32'h0000_0002);
        rd_chk(OFF_WIDE_COUNT, 32'h0000_1234);
        check({31'h0, irq}, 32'h0000_0001);
        xfer(OFF_STATUS, 1'b1, 32'h0000_0002);
        rd_chk(OFF_STATUS, 32'h0000_0000);
        check({31'h0, irq}, 32'h0000_0000);
        xfer(OFF_MASK, 1'b1, 32'h0000_0000);
        ext_trigger_pin <= 1'b1;
        @(posedge clock);
        ext_trigger_pin <= 1'b0;
        rd_chk(OFF_STATUS, 32'h0000_0002);
        check({31'h0, irq}, 32'h0000_0000);
        $display("test trigger and interrupt done");

        // Select bits clear: machine-cycle timer, rollover raises the flag
        xfer(OFF_STATUS, 1'b1, 32'h0000_0003);
        xfer(OFF_WIDE_COUNT, 1'b1, 32'h0000_FFFF);
        xfer(OFF_WIDE_CTRL, 1'b1, 32'h0000_0004);
        repeat (30) @(posedge clock);
        xfer(OFF_WIDE_CTRL, 1'b1, 32'h0000_0000);
        rd_chk(OFF_STATUS, 32'h0000_0001);
        $display("test timer mode flag done");

        // Counter operation: sixteen pin falls make one wide tick
        xfer(OFF_RELOAD, 1'b1, 32'h0000_FFFF);
        xfer(OFF_WIDE_COUNT, 1'b1, 32'h0000_FFFF);
        xfer(OFF_WIDE_CTRL, 1'b1, 32'h0000_0015);
        @(posedge clock);
        tick_mark = tx_n;
        for (int i = 0; i < 16; i++) begin
            @(posedge clock);
            wide_count_pin <= 1'b0;
            @(posedge clock);
            wide_count_pin <= 1'b1;
        end
        repeat (4) @(posedge clock);
        check({16'h0, tx_n - tick_mark}, 32'h0000_0001);
        $display("test counter operation done");

        complete_run();
    end
endmodule
